//--- verilog/ibr_pkg.sv
/*
 package for the serial-over-two-wire bridge: switch positions, unit addresses,
 bit-period counts and the link state codes. Assumes a 125 MHz mclk.
*/
// Notes on behaviour
// - two independent asynchronous serial ports are offered, all their data travelling over the two-wire host bus.
// - port 1 (index 0) is the computer port and port 2 (index 1) is the GPS port.
// - GPS rate comes from switches five (upper) and four (lower): on/on 9600, on/off 4800, off/on 2400, off/off 1200.
// - computer rate comes from switches seven (upper) and six (lower) with the same mapping.
// - every frame has no parity and exactly one stop bit, and the attached equipment must match.
// - switch one enables the GPS port and switch two the computer port; off enables, on disables.
// - a disabled port starts no new frame or transfer; a frame already in progress still completes.
// - switch three off selects the first unit address, on selects the second.
// - the host runs the two-wire protocol and the data exchanges; the bridge only answers as a slave.
package ibr_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int BAUD_9600 = 9600;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_1200 = 1200;
	localparam int DIV_9600 = CLK_HZ / BAUD_9600;
	localparam int DIV_4800 = CLK_HZ / BAUD_4800;
	localparam int DIV_2400 = CLK_HZ / BAUD_2400;
	localparam int DIV_1200 = CLK_HZ / BAUD_1200;
	localparam int CNT_W = 17;
	// switch bank bit positions, 1 = switch on
	localparam int SW_GPS_EN = 0;
	localparam int SW_CMP_EN = 1;
	localparam int SW_ADDR = 2;
	localparam int SW_GPS_LO = 3;
	localparam int SW_GPS_HI = 4;
	localparam int SW_CMP_LO = 5;
	localparam int SW_CMP_HI = 6;
	// unit addresses, values arbitrary
	localparam logic [6:0] UNIT_ADDR_FIRST = 7'h48;
	localparam logic [6:0] UNIT_ADDR_SECOND = 7'h49;
	localparam logic [7:0] EMPTY_READ = 8'h00;
	localparam int FIFO_DEPTH = 2;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] FRAME_SLOTS = 4'hA;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK_A = 3'b010,
		ST_WRITE = 3'b011,
		ST_ACK_W = 3'b100,
		ST_READ = 3'b101,
		ST_MACK = 3'b110
	} ibr_link_e;
endpackage

//--- verilog/ibr_bridge.sv
/*
 two-wire slave to dual serial port bridge, all logic on mclk.
 assumes scl, sda, rxd and the switch bank are asynchronous and are synchronised here;
 sda is open drain: sdaOe high pulls the wire to sdaOut (always low).
*/
module ibr_bridge #(
	parameter int DIV9600 = ibr_pkg::DIV_9600,
	parameter int DIV4800 = ibr_pkg::DIV_4800,
	parameter int DIV2400 = ibr_pkg::DIV_2400,
	parameter int DIV1200 = ibr_pkg::DIV_1200
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// two-wire host link
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// serial ports, index 0 computer, index 1 gps
	input wire logic [1:0] rxd,
	output logic [1:0] txd,
	// switch bank, bit n-1 is switch n, 1 = on
	input wire logic [7:0] configSwitchBank,
	// status
	output logic [1:0] portActive
);
	import ibr_pkg::*;

	function automatic logic [CNT_W-1:0] bitPeriod(input logic hi, input logic lo);
		case ({hi, lo})
			2'b11: bitPeriod = CNT_W'(DIV9600);
			2'b10: bitPeriod = CNT_W'(DIV4800);
			2'b01: bitPeriod = CNT_W'(DIV2400);
			default: bitPeriod = CNT_W'(DIV1200);
		endcase
	endfunction

	logic [1:0] sclS, sdaS;
	logic sclD, sdaD;
	logic [7:0] swS1, swS2;
	logic [1:0] rxS1, rxS2;
	logic [1:0] portEn;
	logic [6:0] myAddr;
	logic sclRise, sclFall, startSeen, stopSeen;
	ibr_link_e state;
	logic [7:0] sh, outByte, txPushData, readByte;
	logic [3:0] bitCnt;
	logic rw, firstByte, portSel;
	logic [1:0] txPush, rxPop;
	logic txRoom [2];
	logic rxValid [2];
	logic [7:0] rxData [2];
	logic txLine [2];

	// every outside level passes two flops first
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{sclS, sdaS, sclD, sdaD} <= 6'h3F;
			{swS1, swS2} <= 16'h0000;
			{rxS1, rxS2} <= 4'hF;
		end else begin
			sclS <= {sclS[0], scl};
			sdaS <= {sdaS[0], sdaIn};
			sclD <= sclS[1];
			sdaD <= sdaS[1];
			swS1 <= configSwitchBank;
			swS2 <= swS1;
			rxS1 <= rxd;
			rxS2 <= rxS1;
		end
	end
	assign portEn[0] = ~swS2[SW_CMP_EN];
	assign portEn[1] = ~swS2[SW_GPS_EN];
	assign myAddr = swS2[SW_ADDR] ? UNIT_ADDR_SECOND : UNIT_ADDR_FIRST;
	assign sclRise = sclS[1] & ~sclD;
	assign sclFall = ~sclS[1] & sclD;
	assign startSeen = sclS[1] & sclD & sdaD & ~sdaS[1];
	assign stopSeen = sclS[1] & sclD & ~sdaD & sdaS[1];
	// empty or disabled port reads as a fixed filler byte
	assign readByte = (portEn[portSel] && rxValid[portSel]) ? rxData[portSel] : EMPTY_READ;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			portActive <= 2'b00;
			sdaOut <= 1'b0;
		end else begin
			portActive <= portEn;
			sdaOut <= 1'b0;
		end
	end
	// two-wire slave engine
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			sh <= 8'h00;
			outByte <= 8'h00;
			bitCnt <= 4'h0;
			rw <= 1'b0;
			firstByte <= 1'b0;
			portSel <= 1'b0;
			sdaOe <= 1'b0;
			txPush <= 2'b00;
			rxPop <= 2'b00;
			txPushData <= 8'h00;
		end else begin
			txPush <= 2'b00;
			rxPop <= 2'b00;
			if (startSeen) begin
				state <= ST_ADDR;
				bitCnt <= 4'h0;
				sdaOe <= 1'b0;
			end else if (stopSeen) begin
				state <= ST_IDLE;
				sdaOe <= 1'b0;
			end else begin
				unique case (state)
					ST_IDLE: begin
					end
					ST_ADDR, ST_WRITE: begin
						if (sclRise) begin
							sh <= {sh[6:0], sdaS[1]};
							bitCnt <= bitCnt + 4'h1;
						end else if (sclFall && bitCnt == BYTE_BITS) begin
							bitCnt <= 4'h0;
							if (state == ST_ADDR) begin
								if (sh[7:1] == myAddr) begin
									sdaOe <= 1'b1;
									rw <= sh[0];
									state <= ST_ACK_A;
								end else begin
									state <= ST_IDLE;
								end
							end else begin
								state <= ST_ACK_W;
								if (firstByte) begin
									// first written byte picks the port
									portSel <= sh[0];
									firstByte <= 1'b0;
									sdaOe <= 1'b1;
								end else if (portEn[portSel] && txRoom[portSel]) begin
									txPush[portSel] <= 1'b1;
									txPushData <= sh;
									sdaOe <= 1'b1;
								end else begin
									// full or disabled: not acknowledged, host retries
									sdaOe <= 1'b0;
								end
							end
						end
					end
					ST_ACK_A: begin
						if (sclFall) begin
							if (rw) begin
								outByte <= {readByte[6:0], 1'b0};
								sdaOe <= ~readByte[7];
								rxPop[portSel] <= portEn[portSel] & rxValid[portSel];
								bitCnt <= 4'h1;
								state <= ST_READ;
							end else begin
								sdaOe <= 1'b0;
								firstByte <= 1'b1;
								bitCnt <= 4'h0;
								state <= ST_WRITE;
							end
						end
					end
					ST_ACK_W: begin
						if (sclFall) begin
							sdaOe <= 1'b0;
							state <= ST_WRITE;
						end
					end
					ST_READ: begin
						if (sclFall) begin
							if (bitCnt == BYTE_BITS) begin
								sdaOe <= 1'b0;
								state <= ST_MACK;
							end else begin
								sdaOe <= ~outByte[7];
								outByte <= {outByte[6:0], 1'b0};
								bitCnt <= bitCnt + 4'h1;
							end
						end
					end
					ST_MACK: begin
						// master ack fetches another byte on the next fall
						if (sclRise) begin
							state <= sdaS[1] ? ST_IDLE : ST_ACK_A;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end
	// one serial port per index
	for (genvar p = 0; p < 2; p++) begin : g_port
		localparam int HI = (p == 0) ? SW_CMP_HI : SW_GPS_HI;
		localparam int LO = (p == 0) ? SW_CMP_LO : SW_GPS_LO;
		logic [CNT_W-1:0] period;
		logic [7:0] mem [FIFO_DEPTH];
		logic wp, rp;
		logic [1:0] cnt;
		logic fifoValid, txReady, pushOk, popOk;
		logic [8:0] txShift;
		logic [3:0] txBits, rxBits;
		logic [CNT_W-1:0] txCnt, rxCnt;
		logic [7:0] rxShift;
		assign period = bitPeriod(swS2[HI], swS2[LO]);
		assign fifoValid = (cnt != 2'h0);
		assign txRoom[p] = (cnt != 2'h2);
		assign txReady = (txBits == 4'h0) & portEn[p];
		assign pushOk = txPush[p] & txRoom[p];
		assign popOk = fifoValid & txReady;
		// two-entry buffer; with both entries waiting behind a busy transmitter the host sees a nack
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				wp <= 1'b0;
				rp <= 1'b0;
				cnt <= 2'h0;
			end else begin
				if (pushOk) begin
					mem[wp] <= txPushData;
					wp <= ~wp;
				end
				if (popOk) begin
					rp <= ~rp;
				end
				cnt <= cnt + {1'b0, pushOk} - {1'b0, popOk};
			end
		end
		// transmitter: start, eight data lsb first, one stop
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				txLine[p] <= 1'b1;
				txShift <= 9'h1FF;
				txBits <= 4'h0;
				txCnt <= '0;
			end else if (popOk) begin
				txLine[p] <= 1'b0;
				txShift <= {1'b1, mem[rp]};
				txBits <= FRAME_SLOTS;
				txCnt <= period - CNT_W'(1);
			end else if (txBits != 4'h0) begin
				if (txCnt == '0) begin
					txCnt <= period - CNT_W'(1);
					txBits <= txBits - 4'h1;
					if (txBits != 4'h1) begin
						txLine[p] <= txShift[0];
						txShift <= {1'b1, txShift[8:1]};
					end
				end else begin
					txCnt <= txCnt - CNT_W'(1);
				end
			end
		end
		// receiver samples mid-bit; disabled port starts no new frame
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				rxBits <= 4'h0;
				rxCnt <= '0;
				rxShift <= 8'h00;
				rxData[p] <= 8'h00;
				rxValid[p] <= 1'b0;
			end else begin
				// clear first so a byte landing in the same cycle wins
				if (rxPop[p]) begin
					rxValid[p] <= 1'b0;
				end
				if (rxBits == 4'h0) begin
					if (portEn[p] && !rxS2[p]) begin
						rxBits <= FRAME_SLOTS;
						rxCnt <= period >> 1;
					end
				end else if (rxCnt != '0) begin
					rxCnt <= rxCnt - CNT_W'(1);
				end else begin
					rxCnt <= period - CNT_W'(1);
					if (rxBits == FRAME_SLOTS) begin
						// glitch shorter than half a bit is dropped
						rxBits <= rxS2[p] ? 4'h0 : rxBits - 4'h1;
					end else if (rxBits != 4'h1) begin
						rxShift <= {rxS2[p], rxShift[7:1]};
						rxBits <= rxBits - 4'h1;
					end else begin
						rxBits <= 4'h0;
						if (rxS2[p]) begin
							// new byte wins over a same-cycle read; unread byte is overwritten
							rxData[p] <= rxShift;
							rxValid[p] <= 1'b1;
						end
					end
				end
			end
		end
	end
	assign txd = {txLine[1], txLine[0]};
endmodule // ibr_bridge

//--- test/ibr_bridge_asserts.sv
/* port checker for ibr_bridge.
 assumes one mclk domain and rst asynchronous, active high. */
module ibr_bridge_asserts #(
	parameter int DIV9600 = 16,
	parameter int DIV4800 = 32,
	parameter int DIV2400 = 48,
	parameter int DIV1200 = 64
) (
	// clock, reset, link
	input wire logic mclk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sdaOut,
	input wire logic sdaOe,
	// serial side and switches
	input wire logic [1:0] txd,
	input wire logic [7:0] configSwitchBank,
	input wire logic [1:0] portActive
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	rst_idle_a: assert property ($fell(rst) |-> txd == 2'h3 && !sdaOe) else $error("busy after reset");
	en_follow_a: assert property ($stable(configSwitchBank) [*6] |->
		portActive == ~{configSwitchBank[0], configSwitchBank[1]}) else $error("enable wrong");
	cmp_quiet_a: assert property (!portActive[0] |-> txd[0]) else $error("disabled port sends");
	gps_quiet_a: assert property (!portActive[1] |-> txd[1]) else $error("disabled port sends");
	pull_only_a: assert property (sdaOe |-> !sdaOut) else $error("sda driven high");
	cmp_start_a: assert property ($fell(txd[0]) |=> !txd[0] [*8]) else $error("start bit short");
	gps_start_a: assert property ($fell(txd[1]) |=> !txd[1] [*8]) else $error("start bit short");
	ack_drive_a: assert property ($rose(sdaOe) |-> !scl) else $error("sda pulled in high phase");
	ack_free_a: assert property ($fell(sdaOe) |-> !scl) else $error("sda freed in high phase");
endmodule // ibr_bridge_asserts
bind ibr_bridge ibr_bridge_asserts #(.DIV9600(DIV9600), .DIV4800(DIV4800), .DIV2400(DIV2400), .DIV1200(DIV1200))
	u_chk (.mclk(mclk), .rst(rst), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe), .txd(txd),
	.configSwitchBank(configSwitchBank), .portActive(portActive));

//--- test/ibr_host.sv
/* two-wire bus master model, host side of the bridge.
 assumes the bench resolves the open-drain wire; hostOe high pulls sda low. */
module ibr_host (
	// clock and bus
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic hostOe
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		scl = 1'b1;
		hostOe = 1'b0;
	end
	task automatic hp();
		repeat (4) @(negedge mclk);
	endtask
	// 64 ns scl: four mclk low, four high
	// sda moves two cycles after scl falls so the slave never sees both move together
	task automatic bitx(input logic b, output logic s);
		repeat (2) @(negedge mclk);
		hostOe = ~b;
		repeat (2) @(negedge mclk);
		scl = 1'b1;
		hp();
		s = sda;
		scl = 1'b0;
	endtask
	task automatic start();
		hp();
		hostOe = 1'b1;
		hp();
		scl = 1'b0;
	endtask
	task automatic stop();
		repeat (2) @(negedge mclk);
		hostOe = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		hostOe = 1'b0;
		hp();
	endtask
	// msb first, ninth slot sends m and returns the sampled level
	task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], s);
			r[i] = s;
		end
		bitx(m, a);
	endtask
endmodule // ibr_host

//--- test/tb_ibr_bridge.sv
/* self-checking bench for ibr_bridge: bus master model plus serial monitors.
 assumes bit periods shortened to 16, 32, 48 and 64 mclk. */
module tb_ibr_bridge;
	timeunit 1ns;
	timeprecision 100ps;
	import ibr_pkg::*;
	localparam int D[4] = '{64, 48, 32, 16};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] rxd = 2'h3;
	logic [7:0] sw = 8'h00;
	logic scl, hostOe, sdaOut, sdaOe;
	logic [1:0] txd, portActive;
	wire logic sda = ~(sdaOe | hostOe);
	logic [7:0] q[2][$];
	int n_mismatch = 0;
	int checks_done = 0;
	int sd = 92599;
	always #4 mclk = ~mclk;
	ibr_bridge #(.DIV9600(16), .DIV4800(32), .DIV2400(48), .DIV1200(64)) i_dut (.mclk(mclk), .rst(rst),
		.scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .rxd(rxd), .txd(txd),
		.configSwitchBank(sw), .portActive(portActive));
	ibr_host i_host (.mclk(mclk), .sda(sda), .scl(scl), .hostOe(hostOe));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	function automatic int dv(input int p);
		return D[p ? sw[4:3] : sw[6:5]];
	endfunction
	// address, selector, then n bytes of which the first k must be acked
	task automatic wr(input logic [6:0] a, input int p, input int n, input int k, input logic aa);
		logic [7:0] r;
		logic [7:0] b;
		logic ak;
		i_host.start();
		i_host.xb({a, 1'b0}, 1'b1, r, ak);
		chk(ak, aa);
		if (!aa) begin
			i_host.xb(8'(p), 1'b1, r, ak);
			chk(ak, 0);
			for (int i = 0; i < n; i++) begin
				b = 8'($random(sd));
				if (i < k) q[p].push_back(b);
				i_host.xb(b, 1'b1, r, ak);
				chk(ak, i >= k);
			end
		end
		i_host.stop();
	endtask
	task automatic ser(input int p, input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd[p] = f[i];
			repeat (dv(p)) @(negedge mclk);
		end
	endtask
	// samples mid-bit, on the rising mclk edge that the bridge flops switch on
	task automatic mon(input int p);
		logic [7:0] b;
		int d;
		forever begin
			@(negedge txd[p]);
			d = dv(p);
			repeat (d / 2) @(posedge mclk);
			chk(txd[p], 0);
			for (int i = 0; i < 8; i++) begin
				repeat (d) @(posedge mclk);
				b[i] = txd[p];
			end
			repeat (d) @(posedge mclk);
			chk(txd[p], 1);
			chk(b, q[p].size() ? q[p].pop_front() : 8'hXX);
		end
	endtask
	initial mon(0);
	initial mon(1);
	initial begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		conclude();
	end
	initial begin
		logic [7:0] r;
		logic [7:0] b;
		logic ak;
		repeat (4) @(negedge mclk);
		chk({txd, sdaOe, portActive}, 8'h18);
		rst = 1'b0;
		repeat (8) @(negedge mclk);
		chk(portActive, 2'h3);
		for (int c = 0; c < 4; c++) begin
			sw = {1'b0, 2'(c), 2'(c), 3'h0};
			repeat (8) @(negedge mclk);
			wr(UNIT_ADDR_FIRST, 0, 1, 1, 1'b0);
			wr(UNIT_ADDR_FIRST, 1, 1, 1, 1'b0);
			repeat (700) @(negedge mclk);
		end
		$display("test rates done");
		sw[2] = 1'b1;
		repeat (8) @(negedge mclk);
		wr(UNIT_ADDR_FIRST, 0, 0, 0, 1'b1);
		wr(UNIT_ADDR_SECOND, 0, 1, 1, 1'b0);
		repeat (200) @(negedge mclk);
		sw[1] = 1'b1;
		repeat (8) @(negedge mclk);
		chk(portActive, 2'h2);
		wr(UNIT_ADDR_SECOND, 0, 1, 0, 1'b0);
		$display("test address and enable done");
		sw[4:3] = 2'h0;
		repeat (8) @(negedge mclk);
		wr(UNIT_ADDR_SECOND, 1, 4, 3, 1'b0);
		repeat (2000) @(negedge mclk);
		$display("test buffer done");
		b = 8'($random(sd));
		ser(1, b);
		repeat (8) @(negedge mclk);
		i_host.start();
		i_host.xb({UNIT_ADDR_SECOND, 1'b1}, 1'b1, r, ak);
		chk(ak, 0);
		i_host.xb(8'hFF, 1'b0, r, ak);
		chk(r, b);
		i_host.xb(8'hFF, 1'b1, r, ak);
		chk(r, EMPTY_READ);
		i_host.stop();
		$display("test read done");
		sw[0] = 1'b1;
		repeat (8) @(negedge mclk);
		chk(portActive, 2'h0);
		wr(UNIT_ADDR_SECOND, 1, 1, 0, 1'b0);
		b = 8'($random(sd));
		ser(1, b);
		sw[0] = 1'b0;
		repeat (8) @(negedge mclk);
		i_host.start();
		i_host.xb({UNIT_ADDR_SECOND, 1'b1}, 1'b1, r, ak);
		chk(ak, 0);
		i_host.xb(8'hFF, 1'b1, r, ak);
		chk(r, EMPTY_READ);
		i_host.stop();
		$display("test gps disable done");
		conclude();
	end
endmodule // tb_ibr_bridge
